// file: core/dsf_front_end.sv
// Serial I/Q input front end with gain stage, flush controls and APB registers
//
// Register access over APB was decided locally.
`timescale 1ns/1ps

// Small FIFO with valid/ready on both sides
module dsf_fifo #(
    parameter int W = 36,
    parameter int D = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full_w;
    logic empty_w;

    // Full when pointers differ only in wrap bit
    assign full_w = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty_w = (wp_r == rp_r);
    assign in_ready = !full_w;
    assign out_valid = !empty_w;
    assign out_data = mem_r[rp_r[AW-1:0]];

    // Write side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
        end else if (in_valid && !full_w) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge pclk) begin
        if (in_valid && !full_w) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end

    // Read side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rp_r <= '0;
        end else if (out_ready && !empty_w) begin
            rp_r <= rp_r + 1'b1;
        end
    end
endmodule : dsf_fifo

module dsf_front_end
    import dsf_pkg::*;
#(
    parameter int NCH = 12,
    parameter int SW = 18,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] line_a_pin,
    input wire logic [NCH-1:0] line_b_pin,
    output logic [NCH/2-1:0] frame_strobe,
    output logic [3:0] flush_pulse,
    output logic [3:0] overflow_flag,
    output logic [NCH-1:0] sample_valid,
    input wire logic [NCH-1:0] sample_ready,
    output logic [NCH-1:0][SW-1:0] sample_a,
    output logic [NCH-1:0][SW-1:0] sample_b
);
    logic [15:0] gain_a_r, gain_b_r, flush_ctl_r, frame_cfg_r;
    logic [3:0] clkdiv_r, ovf_r, test_prev_r, clr_prev_r, flush_r, div_cnt_r;
    logic [3:0] test_rise_w, clr_rise_w, sat_grp_w;
    logic [31:0] prdata_r;
    logic [NCH-1:0] orun_r, sa_meta_r, sa_r, sb_meta_r, sb_r, push_w, fifo_rdy_w;
    logic [6:0] bit_cnt_r, bit_cnt_nxt, total_w, pos_w, invl_w;
    logic strobe_r, done_r, tick_w, in_win_w, last_w, four_line_select, wr_w, rd_w, hit_w;
    logic [NCH-1:0][SW-1:0] shift_a_r, shift_b_r;
    logic [NCH-1:0][SW:0] scaled_a_w, scaled_b_w;
    logic [5:0] nbits_w, idx_w;
    logic [1:0] fsdel_w;

    // Scale by g/8192 with saturation; top bit flags saturation
    function automatic logic [SW:0] scale(input logic [SW-1:0] s, input logic [15:0] g);
        logic signed [SW+16:0] p;
        logic [SW+3:0] q;
        p = $signed(s) * $signed({1'b0, g});
        q = p[SW+16:GAIN_SHIFT];
        if (q[SW+3:SW-1] != '0 && q[SW+3:SW-1] != '1) begin
            scale = {1'b1, q[SW+3], {(SW-1){!q[SW+3]}}};
        end else begin
            scale = {1'b0, q[SW-1:0]};
        end
    endfunction : scale

    // Field extraction
    assign nbits_w = {1'b0, frame_cfg_r[FR_BITS_POS +: 5]} + 6'h01;
    assign fsdel_w = frame_cfg_r[FR_DEL_POS +: 2];
    assign four_line_select = frame_cfg_r[FR_4PIN_POS];
    assign invl_w = frame_cfg_r[FR_INVL_POS +: 7];
    assign total_w = four_line_select ? {1'b0, nbits_w} : {nbits_w, 1'b0};

    // APB decode, zero wait states
    assign idx_w = paddr[7:2];
    assign hit_w = (idx_w == IDX_GAIN_A) || (idx_w == IDX_GAIN_B) || (idx_w == IDX_FLUSH) ||
                   (idx_w == IDX_FRAME) || (idx_w == IDX_CLKDIV) || (idx_w == IDX_STATUS);
    assign wr_w = psel && penable && pwrite && hit_w;
    assign rd_w = psel && !penable && !pwrite;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit_w;
    assign prdata = prdata_r;

    // Software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_a_r <= GAIN_RST;
            gain_b_r <= GAIN_RST;
            flush_ctl_r <= FLUSH_RST;
            frame_cfg_r <= FRAME_RST;
            clkdiv_r <= CLKDIV_RST;
        end else if (wr_w) begin
            if (idx_w == IDX_GAIN_A) gain_a_r <= pwdata[15:0];
            if (idx_w == IDX_GAIN_B) gain_b_r <= pwdata[15:0];
            if (idx_w == IDX_FLUSH) flush_ctl_r <= pwdata[15:0];
            if (idx_w == IDX_FRAME) frame_cfg_r <= pwdata[15:0];
            if (idx_w == IDX_CLKDIV) clkdiv_r <= pwdata[3:0];
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd_w) begin
            case (idx_w)
                IDX_GAIN_A: prdata_r <= {16'h0000, gain_a_r};
                IDX_GAIN_B: prdata_r <= {16'h0000, gain_b_r};
                IDX_FLUSH: prdata_r <= {16'h0000, flush_ctl_r};
                IDX_FRAME: prdata_r <= {16'h0000, frame_cfg_r};
                IDX_CLKDIV: prdata_r <= {28'h0000000, clkdiv_r};
                IDX_STATUS: prdata_r <= 32'(({orun_r, 4'h0}) | {{NCH{1'b0}}, ovf_r});
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    // Edge detect on test and clear fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_prev_r <= 4'h0;
            clr_prev_r <= 4'h0;
        end else begin
            test_prev_r <= flush_ctl_r[FL_TEST_POS +: 4];
            clr_prev_r <= flush_ctl_r[FL_CLR_POS +: 4];
        end
    end
    assign test_rise_w = flush_ctl_r[FL_TEST_POS +: 4] & ~test_prev_r;
    assign clr_rise_w = flush_ctl_r[FL_CLR_POS +: 4] & ~clr_prev_r;

    // Overflow latch; a set wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_r <= 4'h0;
        end else begin
            ovf_r <= (ovf_r & ~clr_rise_w) | test_rise_w | sat_grp_w;
        end
    end
    assign overflow_flag = ovf_r;

    // Automatic flush at each frame unless disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_r <= 4'h0;
        end else begin
            flush_r <= {4{tick_w && bit_cnt_nxt == 7'h00}} & ~flush_ctl_r[FL_DIS_POS +: 4];
        end
    end
    assign flush_pulse = flush_r;

    // Bit clock divider; recovers at once when the divider value shrinks
    assign tick_w = (div_cnt_r >= clkdiv_r);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 4'h0;
        end else begin
            div_cnt_r <= tick_w ? 4'h0 : div_cnt_r + 4'h1;
        end
    end

    // Frame counter in bit clocks
    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        if (tick_w) begin
            bit_cnt_nxt = (bit_cnt_r + 7'h01 >= invl_w) ? 7'h00 : bit_cnt_r + 7'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_r <= 7'h00;
            strobe_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            strobe_r <= (bit_cnt_nxt == 7'h00);
        end
    end
    assign frame_strobe = {(NCH/2){strobe_r}};

    // Capture window
    assign pos_w = bit_cnt_r - {5'h00, fsdel_w};
    assign in_win_w = (bit_cnt_r >= {5'h00, fsdel_w}) && (pos_w < total_w);
    assign last_w = (pos_w == total_w - 7'h01);

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sa_meta_r <= '0;
            sa_r <= '0;
            sb_meta_r <= '0;
            sb_r <= '0;
        end else begin
            sa_meta_r <= line_a_pin;
            sa_r <= sa_meta_r;
            sb_meta_r <= line_b_pin;
            sb_r <= sb_meta_r;
        end
    end

    // MSB-first shifting per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_a_r <= '0;
            shift_b_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= tick_w && in_win_w && last_w;
            for (int c = 0; c < NCH; c++) begin
                if (tick_w && in_win_w) begin
                    if (four_line_select) begin
                        shift_a_r[c] <= {shift_a_r[c][SW-2:0], sa_r[c]};
                        shift_b_r[c] <= {shift_b_r[c][SW-2:0], sb_r[c]};
                    end else if (pos_w < {1'b0, nbits_w}) begin
                        shift_a_r[c] <= {shift_a_r[c][SW-2:0], sa_r[c]};
                    end else begin
                        shift_b_r[c] <= {shift_b_r[c][SW-2:0], sa_r[c]};
                    end
                end else if (tick_w) begin // Short samples keep no stale upper bits
                    shift_a_r[c] <= '0;
                    shift_b_r[c] <= '0;
                end
            end
        end
    end

    // Gain stage and FIFOs
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign scaled_a_w[c] = scale(shift_a_r[c], gain_a_r);
        assign scaled_b_w[c] = scale(shift_b_r[c], gain_b_r);
        assign push_w[c] = done_r;
        dsf_fifo #(.W(2*SW), .D(FIFO_DEPTH)) u_fifo (
            .pclk(pclk),
            .presetn(presetn),
            .in_valid(push_w[c]),
            .in_ready(fifo_rdy_w[c]),
            .in_data({scaled_a_w[c][SW-1:0], scaled_b_w[c][SW-1:0]}),
            .out_valid(sample_valid[c]),
            .out_ready(sample_ready[c]),
            .out_data({sample_a[c], sample_b[c]})
        );
    end

    // Saturation grouped onto four overflow flags
    always_comb begin
        sat_grp_w = 4'h0;
        for (int c = 0; c < NCH; c++) begin
            if (done_r && (scaled_a_w[c][SW] || scaled_b_w[c][SW])) begin
                sat_grp_w[c % 4] = 1'b1;
            end
        end
    end

    // Overrun sticky bits; set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            orun_r <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (push_w[c] && !fifo_rdy_w[c]) begin
                    orun_r[c] <= 1'b1;
                end else if (wr_w && idx_w == IDX_STATUS && pwdata[ST_ORUN_POS + c]) begin
                    orun_r[c] <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    unity_gain_a: assert property (done_r && gain_a_r == GAIN_RST |->
        scaled_a_w[0][SW-1:0] == shift_a_r[0])
        else $error("unity gain altered line A sample");
    gain_b_zero_a: assert property (done_r && gain_b_r == 16'h0000 |->
        scaled_b_w[0] == '0)
        else $error("zero gain B did not give zero");
    flush_dis_a: assert property (flush_ctl_r[FL_DIS_POS] |=> !flush_r[0])
        else $error("flush issued while disabled");
    test_edge_a: assert property (test_rise_w[0] |=> ovf_r[0])
        else $error("test edge did not set overflow");
    clr_level_a: assert property (flush_ctl_r[FL_CLR_POS] && $past(flush_ctl_r[FL_CLR_POS])
        && ovf_r[0] |=> ovf_r[0])
        else $error("held clear level cleared overflow");
    bits_len_a: assert property (done_r |-> $past(pos_w) == $past(total_w) - 7'h01)
        else $error("sample ended at wrong bit");
    msb_delay_a: assert property (bit_cnt_r == {5'h00, fsdel_w} && total_w != 7'h00 |->
        in_win_w)
        else $error("capture did not start at delay");
    mode_len_a: assert property (done_r && !$past(four_line_select) |->
        $past(pos_w) == {$past(nbits_w), 1'b0} - 7'h01)
        else $error("two-line sample length wrong");
    frame_wrap_a: assert property (tick_w && bit_cnt_r + 7'h01 >= invl_w |=>
        bit_cnt_r == 7'h00 ##0 strobe_r)
        else $error("frame did not wrap");
    div_full_a: assert property (clkdiv_r == 4'h0 && $stable(clkdiv_r) |-> tick_w)
        else $error("full rate missed a bit clock");
    strobe_pair_a: assert property ($past(presetn) |->
        frame_strobe == {(NCH/2){bit_cnt_r == 7'h00}})
        else $error("strobes out of step with frame");

    four_line_c: cover property (four_line_select && done_r);
    two_line_c: cover property (!four_line_select && done_r);
    overrun_c: cover property (push_w[0] && !fifo_rdy_w[0]);
    ovf_clear_c: cover property (ovf_r[0] ##1 clr_rise_w[0] ##1 !ovf_r[0]);
endmodule : dsf_front_end

// file: core/dsf_pkg.sv
// Package: register map, field layout and reset values of the serial front end
package dsf_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_GAIN_A = 6'h0c;
    localparam logic [5:0] IDX_GAIN_B = 6'h0d;
    localparam logic [5:0] IDX_FLUSH = 6'h10;
    localparam logic [5:0] IDX_FRAME = 6'h1b;
    localparam logic [5:0] IDX_CLKDIV = 6'h1c;
    localparam logic [5:0] IDX_STATUS = 6'h1e;
    // Reset values
    localparam logic [15:0] GAIN_RST = 16'h2000;
    localparam logic [15:0] FLUSH_RST = 16'h0000;
    localparam logic [15:0] FRAME_RST = 16'h8932;
    localparam logic [3:0] CLKDIV_RST = 4'h1;
    // Gain is applied as g / 2**GAIN_SHIFT
    localparam int GAIN_SHIFT = 13;
    // Flush control fields, four bits each
    localparam int FL_DIS_POS = 12;
    localparam int FL_TEST_POS = 8;
    localparam int FL_CLR_POS = 4;
    // Frame config fields
    localparam int FR_BITS_POS = 11;
    localparam int FR_DEL_POS = 8;
    localparam int FR_4PIN_POS = 7;
    localparam int FR_INVL_POS = 0;
    // Status layout
    localparam int ST_OVF_POS = 0;
    localparam int ST_ORUN_POS = 4;
endpackage : dsf_pkg

// file: tb/dsf_serial_source.sv
// Serial sample source for one channel's two data lines
`timescale 1ns/1ps
module dsf_serial_source (
    input wire logic pclk,
    input wire logic strobe,
    input wire logic [3:0] div,
    input wire logic [1:0] delay,
    input wire logic [4:0] bits_m1,
    input wire logic four_line,
    input wire logic [17:0] word_a,
    input wire logic [17:0] word_b,
    output logic line_a,
    output logic line_b
);
    int cyc = -1;
    int pos;
    int n;
    logic prev = 1'b1;
    logic [17:0] sa;
    logic [17:0] sb;
    // Lines start at opposite levels
    initial begin
        line_a = 1'b0;
        line_b = 1'b1;
    end
    // Frame starts on a strobe rise; MSB first, one bit per bit clock
    always @(posedge pclk) begin
        if (strobe === 1'b1 && prev === 1'b0) begin
            cyc = 0;
            sa = word_a;
            sb = word_b;
        end else if (cyc >= 0) begin
            cyc++;
        end
        prev = strobe;
        n = int'(bits_m1) + 1;
        pos = (cyc < 0) ? -1 : cyc / (int'(div) + 1) - int'(delay);
        if (pos >= 0 && pos < n) begin
            line_a <= sa[n-1-pos];
            line_b <= four_line ? sb[n-1-pos] : ~line_b;
        end else if (!four_line && pos >= n && pos < 2 * n) begin
            line_a <= sb[2*n-1-pos];
            line_b <= ~line_b;
        end else begin
            // No data outside the sample: lines toggle
            line_a <= ~line_a;
            line_b <= ~line_b;
        end
    end
endmodule : dsf_serial_source

// file: tb/testbench.sv
// Self-checking bench for the serial front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench import dsf_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cfour;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] line_a_pin, line_b_pin, sample_valid, sample_ready;
    logic [5:0] frame_strobe;
    logic [3:0] flush_pulse, overflow_flag, cdiv, dis, fv;
    logic [11:0][17:0] sample_a, sample_b;
    logic [17:0] wa, wb;
    logic [15:0] ga, gb;
    logic [4:0] cbits;
    logic [1:0] cdel;
    int n_mismatch = 0;
    int n_tests = 0;
    int qa[$], qb[$];
    int h, p, np, d, invl;
    localparam logic [19:0] FTAB [8] = '{20'h00000, 20'h03003, 20'h0f00f, 20'h0f10e,
        20'h0e10e, 20'h0f10f, 20'h0000f, 20'h00f00};
    dsf_front_end #(.NCH(12), .SW(18), .FIFO_DEPTH(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_a_pin(line_a_pin),
        .line_b_pin(line_b_pin), .frame_strobe(frame_strobe), .flush_pulse(flush_pulse),
        .overflow_flag(overflow_flag), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_a(sample_a), .sample_b(sample_b));
    // One source per channel, strobed by its pair's strobe
    for (genvar c = 0; c < 12; c++) begin : g_src
        dsf_serial_source u_src (.pclk(pclk), .strobe(frame_strobe[c/2]), .div(cdiv),
            .delay(cdel), .bits_m1(cbits), .four_line(cfour), .word_a(wa + 18'(c)),
            .word_b(wb + 18'(c)), .line_a(line_a_pin[c]), .line_b(line_b_pin[c]));
    end
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        fail_out();
    end
    // Gain model: signed sample times gain over 8192, saturated to 18 bits
    function automatic logic [17:0] scale(input logic [17:0] s, input logic [15:0] g);
        longint v;
        v = (longint'($signed(s)) * longint'(g)) >>> 13;
        if (v > 131071) v = 131071;
        if (v < -131072) v = -131072;
        return v[17:0];
    endfunction : scale
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic fail_out();
        n_mismatch++;
        end_sim();
    endtask : fail_out
    // APB transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] dat);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) fail_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string nm, input logic [5:0] i, input logic [31:0] e,
        input logic ee);
        apb(1'b0, i, 32'h0);
        `CHK(nm, e, rd)
        `CHK("pslverr", ee, err)
    endtask : rchk
    // Return at the edge that first sees a strobe rise
    task automatic wait_strobe();
        int k;
        logic prev;
        prev = 1'b1;
        for (k = 0; k < 4000; k++) begin
            @(posedge pclk);
            if (frame_strobe[0] === 1'b1 && prev === 1'b0) return;
            prev = frame_strobe[0];
        end
        fail_out();
    endtask : wait_strobe
    // Strobe width, frame length and flush pulses over one frame
    task automatic measure();
        logic prev;
        {h, p, np, prev, fv} = {32'd1, 32'd0, 32'd0, 1'b1, 4'h0};
        repeat (4000) begin
            @(posedge pclk);
            p++;
            `CHK("strobe_pair", {6{frame_strobe[0]}}, frame_strobe)
            if (flush_pulse !== 4'h0) {np, fv} = {np + 1, flush_pulse};
            if (frame_strobe[0] === 1'b1 && prev === 1'b0) return;
            if (frame_strobe[0] === 1'b1) h++;
            prev = frame_strobe[0];
        end
        fail_out();
    endtask : measure
    // Fill the buffer past full with stalled consumer, then drain and compare
    task automatic stream(input logic zb);
        int f, k, c, b;
        logic [17:0] m;
        b = 7 + $urandom_range(10);
        m = 18'((1 << (b + 1)) - 1);
        ga = 16'($urandom);
        gb = zb ? 16'h0000 : 16'($urandom);
        cdel <= 2'($urandom);
        cdiv <= 4'h3;
        cbits <= 5'(b);
        apb(1'b1, IDX_CLKDIV, 32'h3);
        apb(1'b1, IDX_FRAME, {16'h0, 5'(b), 1'b0, cdel, cfour, 7'd50});
        apb(1'b1, IDX_GAIN_A, {16'h0, ga});
        apb(1'b1, IDX_GAIN_B, {16'h0, gb});
        rchk("gain_a", IDX_GAIN_A, {16'h0, ga}, 1'b0);
        rchk("gain_b", IDX_GAIN_B, {16'h0, gb}, 1'b0);
        apb(1'b1, IDX_STATUS, 32'hfff0);
        sample_ready <= '1;
        for (f = 0; f < 7; f++) begin
            wa <= 18'($urandom);
            wb <= 18'($urandom);
            wait_strobe();
            if (f == 1) sample_ready <= '0;
            if (f >= 1 && f <= 4) qa.push_back(int'(wa));
            if (f >= 1 && f <= 4) qb.push_back(int'(wb));
        end
        apb(1'b0, IDX_STATUS, 32'h0);
        `CHK("overrun", 12'hfff, rd[15:4])
        for (k = 0; k < 500 && qa.size() > 0; k++) begin
            @(posedge pclk);
            if (sample_ready[0] === 1'b1 && sample_valid[0] === 1'b1) begin
                for (c = 0; c < 12; c++) begin
                    `CHK("sample_a", scale(18'((qa[0] + c) & m), ga), sample_a[c])
                    `CHK("sample_b", scale(18'((qb[0] + c) & m), gb), sample_b[c])
                end
                void'(qa.pop_front());
                void'(qb.pop_front());
            end
            sample_ready <= {12{1'($urandom)}};
        end
        if (qa.size() > 0) fail_out();
        @(posedge pclk);
        sample_ready <= '1;
    endtask : stream
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, cfour} = '0;
        {wa, wb, ga, gb, dis} = '0;
        {cdiv, cdel, cbits, d, invl} = {4'h1, 2'h1, 5'd17, 32'd1, 32'd50};
        sample_ready = '1;
        void'($urandom(51091));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("gain_a", IDX_GAIN_A, 32'h2000, 1'b0);
        rchk("gain_b", IDX_GAIN_B, 32'h2000, 1'b0);
        rchk("flush", IDX_FLUSH, 32'h0, 1'b0);
        rchk("frame", IDX_FRAME, 32'h8932, 1'b0);
        rchk("clkdiv", IDX_CLKDIV, 32'h1, 1'b0);
        apb(1'b1, 6'h01, 32'hffff);
        rchk("unmapped", 6'h01, 32'h0, 1'b1);
        for (int t = 0; t < 4; t++) begin
            if (t > 0) begin
                d = $urandom_range(15);
                invl = 2 + $urandom_range(18);
                dis = (t == 3) ? 4'hf : 4'($urandom);
                apb(1'b1, IDX_CLKDIV, {28'h0, 4'(d)});
                apb(1'b1, IDX_FRAME, {16'h0, 5'd17, 3'b001, 1'b0, 7'(invl)});
                apb(1'b1, IDX_FLUSH, {16'h0, dis, 12'h0});
            end
            wait_strobe();
            wait_strobe();
            measure();
            `CHK("strobe_len", d + 1, h)
            `CHK("frame_len", invl * (d + 1), p)
            `CHK("flush_count", (dis == 4'hf) ? 0 : 1, np)
            `CHK("flush_groups", (dis == 4'hf) ? 4'h0 : ~dis, fv)
        end
        foreach (FTAB[i]) begin
            apb(1'b1, IDX_FLUSH, {16'h0, FTAB[i][19:4]});
            apb(1'b0, IDX_STATUS, 32'h0);
            `CHK("overflow_flag", FTAB[i][3:0], overflow_flag)
            `CHK("status_ovf", FTAB[i][3:0], rd[3:0])
        end
        for (int mo = 0; mo < 2; mo++) begin
            cfour <= 1'(mo);
            stream(1'(mo));
        end
        end_sim();
    end
endmodule : testbench
